/* rtl/lfc_line_ctrl.sv */
`timescale 1ns/1ns
module lfc_line_ctrl (
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               resetn,
  // mode strap
  input  wire logic               strap_parallel,
  // five-wire interface inputs
  input  wire logic               if_dclk,
  input  wire logic               if_ncs_in,
  input  wire logic               if_eia,
  input  wire logic               if_ci,
  input  wire logic               if_dio_in,
  // five-wire interface outputs
  output logic                    if_dio_out,
  output logic                    if_dio_oe_n,
  output logic                    if_ncs_out,
  output logic                    if_ncs_oe_n,
  // line sense
  input  wire logic               ring_zero_cross,
  input  wire logic               loop_closed,
  input  wire logic               ground_key,
  input  wire logic               ilim_active,
  input  wire logic               half_battery,
  input  wire logic               thermal_ok,
  // line drive settings
  output lfc_pkg::lfc_feed_t      feed,
  output logic                    ring_drive,
  output logic                    stat_off_hook,
  output logic [7:0]              cmd_byte
);

  logic       s_dclk;
  logic       s_ncs;
  logic       s_eia;
  logic       s_ci;
  logic       s_dio;
  logic       s_zc;
  logic       s_loop;
  logic       s_strap;
  logic       s_sel;
  logic       dclk_d_ff;
  logic       ncs_d_ff;
  logic       zc_d_ff;
  logic [7:0] shift_ff;
  logic [2:0] rd_idx_ff;
  logic [7:0] cmd_ff;
  logic       cmd_new;
  logic [7:0] eff_cmd;
  logic       ring_on_ff;
  logic       tripped_ff;
  logic [1:0] period_ff;
  logic       off_hook_ff;
  logic       ramp_ff;
  logic [4:0] status;
  logic       dclk_rise;
  logic       ncs_rise;
  logic       zc_rise;
  logic       ring_mode;
  logic       ring_want;

  // ==========================================
  // current limit code from the two limit bits
  function automatic lfc_pkg::lfc_ilim_t ilim_decode(input logic lo, input logic hi);
    ilim_decode = lfc_pkg::lfc_ilim_t'({lo, lo ^ hi});
  endfunction : ilim_decode

  // ==========================================
  // status bit picked by the serial read pointer
  function automatic logic stat_bit(input logic [4:0] st, input logic [2:0] idx);
    stat_bit = (idx < 3'(lfc_pkg::SER_STAT_BITS)) ? st[idx] : 1'b0;
  endfunction : stat_bit

  // ==========================================
  // input synchronisers
  lfc_sync #(.W(8)) u_sync (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .async_in ({if_dclk, ~if_ncs_in, if_eia, if_ci, if_dio_in,
                ring_zero_cross, loop_closed, strap_parallel}),
    .sync_out ({s_dclk, s_sel, s_eia, s_ci, s_dio, s_zc, s_loop, s_strap})
  );
  // chip select enters inverted so its reset value is the idle high
  assign s_ncs = ~s_sel;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dclk_d_ff <= 1'b0;
      ncs_d_ff  <= 1'b1;
      zc_d_ff   <= 1'b0;
    end
    else
    begin
      dclk_d_ff <= s_dclk;
      ncs_d_ff  <= s_ncs;
      zc_d_ff   <= s_zc;
    end
  end

  assign dclk_rise = s_dclk & ~dclk_d_ff;
  assign ncs_rise  = s_ncs & ~ncs_d_ff;
  assign zc_rise   = s_zc & ~zc_d_ff;

  // ==========================================
  // serial write shift and read pointer
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      shift_ff  <= lfc_pkg::CMD_RESET_VAL;
      rd_idx_ff <= 3'h0;
    end
    else if (s_ncs)
      rd_idx_ff <= 3'h0;
    else if (dclk_rise)
    begin
      if (!s_eia)
        shift_ff <= {s_dio, shift_ff[7:1]};
      else if (rd_idx_ff != 3'(lfc_pkg::SER_STAT_BITS))
        rd_idx_ff <= rd_idx_ff + 3'h1;
    end
  end

  // latch on chip select release after a write
  assign cmd_new = !s_strap && !s_ci && !s_eia && ncs_rise;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      cmd_ff <= lfc_pkg::CMD_RESET_VAL;
    else if (cmd_new)
      cmd_ff <= shift_ff;
  end

  // ==========================================
  // effective command: parallel pins bypass registers
  always_comb
  begin
    if (s_strap)
      eff_cmd = {8'h80 | {5'h00, s_dclk, s_ci, s_eia}};
    else
      eff_cmd = cmd_ff;
  end
  assign cmd_byte = eff_cmd;

  // ==========================================
  // command decode
  assign ring_mode = eff_cmd[lfc_pkg::CMD_RING_SEL_POS]
                     && !eff_cmd[lfc_pkg::CMD_IMPEDANCE_POS];

  always_comb
  begin
    feed = '0;
    if (eff_cmd == 8'h00)
    begin
      feed.mode        = lfc_pkg::LFC_MODE_PWRDN;
      feed.sensors_off = 1'b1;
    end
    else if (ring_mode)
    begin
      feed.mode        = lfc_pkg::LFC_MODE_RING;
      feed.ring_preset = 1'b1;
      feed.ring_gate   = ring_on_ff;
    end
    else if (eff_cmd[lfc_pkg::CMD_IMPEDANCE_POS])
    begin
      feed.mode                 = lfc_pkg::LFC_MODE_CONV;
      feed.boosted_battery_feed = eff_cmd[lfc_pkg::CMD_BOOST_POS];
      feed.reverse_polarity     = eff_cmd[lfc_pkg::CMD_POLARITY_POS];
      feed.metering_on          = ramp_ff;
      feed.metering_high        = eff_cmd[lfc_pkg::CMD_LEVEL_POS];
      feed.drop_25v             = eff_cmd[lfc_pkg::CMD_LEVEL_POS];
    end
    else
      feed.mode = lfc_pkg::LFC_MODE_STANDBY;
    feed.current_limit = ilim_decode(eff_cmd[lfc_pkg::CMD_ILIM_LO_POS],
                                     eff_cmd[lfc_pkg::CMD_ILIM_HI_POS]);
    if (feed.mode == lfc_pkg::LFC_MODE_RING)
      feed.reverse_polarity = 1'b0;
  end

  // ==========================================
  // metering gate: request held, envelope shaped outside
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      ramp_ff <= 1'b0;
    else
      ramp_ff <= eff_cmd[lfc_pkg::CMD_IMPEDANCE_POS]
                 && eff_cmd[lfc_pkg::CMD_TIMING_POS];
  end

  // ==========================================
  // ringing cadence at zero crossings
  assign ring_want = ring_mode && eff_cmd[lfc_pkg::CMD_TIMING_POS]
                     && !tripped_ff && !off_hook_ff;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      ring_on_ff <= 1'b0;
    // leaving ringing waits for a zero crossing, a trip cuts at once
    else if (s_loop && ring_on_ff && !tripped_ff)
      ring_on_ff <= 1'b0;
    else if (zc_rise)
      ring_on_ff <= ring_want;
  end
  assign ring_drive = ring_on_ff;

  // ==========================================
  // ring trip confirmation
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tripped_ff <= 1'b0;
      period_ff  <= 2'h0;
    end
    else if (!ring_mode)
    begin
      tripped_ff <= 1'b0;
      period_ff  <= 2'h0;
    end
    else if (!tripped_ff)
    begin
      if (s_loop && ring_on_ff)
      begin
        tripped_ff <= 1'b1;
        period_ff  <= 2'h0;
      end
    end
    else if (!s_loop)
      tripped_ff <= 1'b0;
    else if (zc_rise && period_ff != 2'(lfc_pkg::TRIP_CHECK_PERIODS))
      period_ff <= period_ff + 2'h1;
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      off_hook_ff <= 1'b0;
    else if (tripped_ff && s_loop
             && period_ff == 2'(lfc_pkg::TRIP_CHECK_PERIODS))
      off_hook_ff <= 1'b1;
    else if (cmd_new)
      off_hook_ff <= 1'b0;
  end

  // ==========================================
  // status and output pins
  assign status = {~thermal_ok, half_battery, ilim_active, ground_key,
                   off_hook_ff | (s_loop & ~ring_mode)};
  assign stat_off_hook = status[0];

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      if_dio_out  <= 1'b0;
      if_dio_oe_n <= 1'b1;
      if_ncs_out  <= 1'b0;
      if_ncs_oe_n <= 1'b1;
    end
    else if (s_strap)
    begin
      if_ncs_out  <= status[0];
      if_ncs_oe_n <= 1'b0;
      if_dio_out  <= status[1];
      if_dio_oe_n <= 1'b0;
    end
    else
    begin
      if_ncs_out  <= status[0] | status[1];
      if_ncs_oe_n <= ~s_ci;
      if_dio_out  <= stat_bit(status, rd_idx_ff);
      if_dio_oe_n <= ~(s_eia && !s_ncs && !s_ci);
    end
  end

endmodule : lfc_line_ctrl

/* rtl/lfc_pkg.sv */
package lfc_pkg;

  // ==========================================
  // command byte field positions
  localparam int CMD_IMPEDANCE_POS   = 0;
  localparam int CMD_TIMING_POS      = 1;
  localparam int CMD_RING_SEL_POS    = 2;
  localparam int CMD_LEVEL_POS       = 3;
  localparam int CMD_POLARITY_POS    = 4;
  localparam int CMD_BOOST_POS       = 5;
  localparam int CMD_ILIM_LO_POS     = 6;
  localparam int CMD_ILIM_HI_POS     = 7;
  localparam logic [7:0] CMD_RESET_VAL = 8'h00;

  // ==========================================
  // serial frame
  localparam int SER_CMD_BITS  = 8;
  localparam int SER_STAT_BITS = 5;

  // ==========================================
  // ring trip check length in ringing periods
  localparam int TRIP_CHECK_PERIODS = 2;

  // ==========================================
  // limit levels and modes
  typedef enum logic [1:0] {
    LFC_ILIM_25MA = 2'h0,
    LFC_ILIM_30MA = 2'h1,
    LFC_ILIM_45MA = 2'h2,
    LFC_ILIM_70MA = 2'h3
  } lfc_ilim_t;

  typedef enum logic [1:0] {
    LFC_MODE_PWRDN,
    LFC_MODE_STANDBY,
    LFC_MODE_CONV,
    LFC_MODE_RING
  } lfc_mode_t;

  // ==========================================
  // decoded line settings
  typedef struct packed {
    lfc_mode_t mode;
    logic      boosted_battery_feed;
    logic      reverse_polarity;
    lfc_ilim_t current_limit;
    logic      metering_high;
    logic      metering_on;
    logic      drop_25v;
    logic      ring_preset;
    logic      ring_gate;
    logic      sensors_off;
  } lfc_feed_t;

endpackage : lfc_pkg

/* rtl/lfc_sync.sv */
`timescale 1ns/1ns
module lfc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  // data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;

  // ==========================================
  // three stages, accept when two and three agree
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s1_ff    <= '0;
      s2_ff    <= '0;
      s3_ff    <= '0;
      sync_out <= '0;
    end
    else
    begin
      s1_ff <= async_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      for (int i = 0; i < W; i++)
      begin
        if (s2_ff[i] == s3_ff[i])
          sync_out[i] <= s3_ff[i];
      end
    end
  end

endmodule : lfc_sync

/* test/lfc_ctrl_model.sv */
`timescale 1ns/1ns
module lfc_ctrl_model (
  // clock
  input  wire logic sys_clk,
  // five wires toward the block
  output logic      dclk,
  output logic      ncs,
  output logic      eia,
  output logic      ci,
  output logic      dio,
  input  wire logic dio_pin
);
  initial {dclk, ncs, eia, ci, dio} = 5'h08;

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step

  // ==========================================
  // serial write, bit0 first
  task automatic write_cmd(input logic [7:0] v);
    eia = 1'b0;
    ncs = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      dio = v[i];
      step(5);
      dclk = 1'b1;
      step(5);
      dclk = 1'b0;
    end
    step(2);
    ncs = 1'b1;
    dio = ~v[7];
    step(5);
  endtask : write_cmd

  // ==========================================
  // serial status read
  task automatic read_stat(output logic [4:0] s);
    eia = 1'b1;
    ncs = 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      step(6);
      s[i] = dio_pin;
      dclk = 1'b1;
      step(5);
      dclk = 1'b0;
    end
    ncs = 1'b1;
    step(1);
    eia = 1'b0;
  endtask : read_stat

  task automatic set_par(input logic [2:0] v);
    {dclk, ci, eia} = v;
  endtask : set_par
endmodule : lfc_ctrl_model

/* test/lfc_line_ctrl_assertions.sv */
`timescale 1ns/1ns
module lfc_line_ctrl_assertions (
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               resetn,
  // watched ports
  input  wire logic               strap_parallel,
  input  wire logic               if_ncs_in,
  input  wire logic               loop_closed,
  input  wire lfc_pkg::lfc_feed_t feed,
  input  wire logic               ring_drive,
  input  wire logic [7:0]         cmd_byte
);
  // ==========================================
  // mode helpers
  logic conv;
  logic ring;
  assign conv = feed.mode == lfc_pkg::LFC_MODE_CONV;
  assign ring = feed.mode == lfc_pkg::LFC_MODE_RING;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // ==========================================
  // properties
  property p_boost; conv |-> feed.boosted_battery_feed == cmd_byte[5]; endproperty
  a_boost: assert property (p_boost)
    else $error("battery feed wrong");
  property p_pol; conv |-> feed.reverse_polarity == cmd_byte[4]; endproperty
  a_pol: assert property (p_pol)
    else $error("polarity wrong");
  property p_ilim;
    conv |-> feed.current_limit == {cmd_byte[6], cmd_byte[6] ^ cmd_byte[7]};
  endproperty
  a_ilim: assert property (p_ilim)
    else $error("current limit wrong");
  property p_meter;
    feed.metering_on == (conv && $past(cmd_byte[1]) && $past(cmd_byte[0]));
  endproperty
  a_meter: assert property (p_meter)
    else $error("metering gate wrong");
  property p_level; conv |-> {feed.metering_high, feed.drop_25v} == {2{cmd_byte[3]}}; endproperty
  a_level: assert property (p_level)
    else $error("level bit wrong");
  property p_ring;
    cmd_byte[2:0] == 3'h6 |-> ring && feed.ring_preset && !feed.reverse_polarity;
  endproperty
  a_ring: assert property (p_ring)
    else $error("ringing setup wrong");
  property p_pwrdn;
    cmd_byte == 8'h00 |-> feed.mode == lfc_pkg::LFC_MODE_PWRDN && feed.sensors_off;
  endproperty
  a_pwrdn: assert property (p_pwrdn)
    else $error("power down wrong");
  property p_rdrv; $rose(ring_drive) |-> ring && cmd_byte[1]; endproperty
  a_rdrv: assert property (p_rdrv)
    else $error("ringing without gate");
  property p_trip; (ring && loop_closed) [*8] |-> !ring_drive; endproperty
  a_trip: assert property (p_trip)
    else $error("ringing not suspended");
  property p_hold; (!strap_parallel && if_ncs_in) [*8] |=> $stable(cmd_byte); endproperty
  a_hold: assert property (p_hold)
    else $error("command changed idle");
  property p_par; strap_parallel [*8] |-> cmd_byte[7:3] == 5'h10; endproperty
  a_par: assert property (p_par)
    else $error("parallel fixed bits wrong");
endmodule : lfc_line_ctrl_assertions

bind lfc_line_ctrl lfc_line_ctrl_assertions u_chk (
  .sys_clk(sys_clk), .resetn(resetn), .strap_parallel(strap_parallel), .if_ncs_in(if_ncs_in),
  .loop_closed(loop_closed), .feed(feed), .ring_drive(ring_drive), .cmd_byte(cmd_byte)
);

/* test/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  logic               sys_clk;
  logic               resetn;
  logic               strap_parallel;
  logic               ring_zero_cross;
  logic               zc_on;
  logic               loop_closed;
  logic [3:0]         sense;
  logic               m_dclk, m_ncs, m_eia, m_ci, m_dio;
  logic               dio_out, dio_oe_n, ncs_out, ncs_oe_n, ring_drive, stat_off_hook;
  logic [7:0]         cmd_byte;
  logic [7:0]         b;
  logic [4:0]         st;
  lfc_pkg::lfc_feed_t feed;
  wire                dio_pin = dio_oe_n ? m_dio : dio_out;
  wire                ncs_pin = ncs_oe_n ? m_ncs : ncs_out;
  int                 num_errors = 0;
  int                 checks_done = 0;

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  lfc_line_ctrl u_lfc_line_ctrl (
    .sys_clk(sys_clk), .resetn(resetn), .strap_parallel(strap_parallel), .if_dclk(m_dclk),
    .if_ncs_in(ncs_pin), .if_eia(m_eia), .if_ci(m_ci), .if_dio_in(dio_pin),
    .if_dio_out(dio_out), .if_dio_oe_n(dio_oe_n), .if_ncs_out(ncs_out), .if_ncs_oe_n(ncs_oe_n),
    .ring_zero_cross(ring_zero_cross), .loop_closed(loop_closed), .ground_key(sense[0]),
    .ilim_active(sense[1]), .half_battery(sense[2]), .thermal_ok(sense[3]), .feed(feed),
    .ring_drive(ring_drive), .stat_off_hook(stat_off_hook), .cmd_byte(cmd_byte)
  );

  lfc_ctrl_model u_lfc_ctrl_model (
    .sys_clk(sys_clk), .dclk(m_dclk), .ncs(m_ncs), .eia(m_eia), .ci(m_ci), .dio(m_dio),
    .dio_pin(dio_pin)
  );

  // ==========================================
  // ringing waveform, period 40 cycles
  initial
  begin
    ring_zero_cross = 1'b0;
    forever
    begin
      repeat (20) @(posedge sys_clk);
      #1 ring_zero_cross = zc_on ? ~ring_zero_cross : 1'b0;
    end
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic test_done();
    if (num_errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done

  task automatic wr(input logic [7:0] v);
    u_lfc_ctrl_model.write_cmd(v);
    u_lfc_ctrl_model.step(10);
    check("cmd_byte", cmd_byte, v);
  endtask : wr

  initial
  begin
    #3000000;
    num_errors++;
    test_done();
  end

  // ==========================================
  // main sequence
  initial
  begin
    resetn         = 1'b0;
    strap_parallel = 1'b0;
    zc_on          = 1'b0;
    loop_closed    = 1'b0;
    void'($urandom(32'h6BC16826));
    sense          = 4'($urandom);
    repeat (20) @(posedge sys_clk);
    #1 resetn = 1'b1;
    u_lfc_ctrl_model.step(5);
    check("pwrdn", 8'({feed.mode, feed.sensors_off}), 8'h01);
    for (int i = 0; i < 16; i++)
    begin
      b = (i < 4) ? {i[1:0], 6'h01} : 8'($urandom) | 8'h01;
      sense = 4'($urandom);
      wr(b);
      check("boost", 8'(feed.boosted_battery_feed), 8'(b[5]));
      check("pol", 8'(feed.reverse_polarity), 8'(b[4]));
      check("ilim", 8'(feed.current_limit), 8'({b[6], b[6] ^ b[7]}));
      check("meter", 8'({feed.metering_on, feed.metering_high, feed.drop_25v}),
            8'({b[1], b[3], b[3]}));
    end
    wr(8'h40);
    check("sby", 8'(feed.mode), 8'(lfc_pkg::LFC_MODE_STANDBY));
    wr(8'h16);
    check("ring", 8'({feed.mode, feed.ring_preset, feed.reverse_polarity}), 8'h0E);
    check("no zc", 8'(ring_drive), 8'h00);
    zc_on = 1'b1;
    u_lfc_ctrl_model.step(50);
    check("ringing", 8'(ring_drive), 8'h01);
    loop_closed = 1'b1;
    u_lfc_ctrl_model.step(15);
    check("suspend", 8'({feed.mode, ring_drive}), 8'h06);
    u_lfc_ctrl_model.step(20);
    loop_closed = 1'b0;
    u_lfc_ctrl_model.step(50);
    check("resume", 8'({ring_drive, stat_off_hook}), 8'h02);
    loop_closed = 1'b1;
    u_lfc_ctrl_model.step(130);
    check("trip", 8'({ring_drive, stat_off_hook}), 8'h01);
    u_lfc_ctrl_model.read_stat(st);
    check("stat", 8'(st), 8'({~sense[3], sense[2:0], 1'b1}));
    loop_closed = 1'b0;
    zc_on = 1'b0;
    strap_parallel = 1'b1;
    u_lfc_ctrl_model.set_par(3'h1);
    u_lfc_ctrl_model.step(10);
    check("par conv", cmd_byte, 8'h81);
    check("par stat", 8'({ncs_pin, dio_pin, ncs_oe_n, dio_oe_n}), 8'({1'b1, sense[0], 2'b00}));
    u_lfc_ctrl_model.set_par(3'h6);
    u_lfc_ctrl_model.step(10);
    check("par ring", 8'(feed.mode), 8'(lfc_pkg::LFC_MODE_RING));
    test_done();
  end
endmodule : tb_top
